// ### hw/spg_defs.vh
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH
`define SPG_CLK_MHZ 250
`define SPG_PUW_MIN_US 100
`define SPG_PUW_MAX_US 500
`define SPG_VSL_MIN_US 300
`define SPG_PUW_CYCLES (`SPG_PUW_MIN_US * `SPG_CLK_MHZ)
`define SPG_BYTE_BITS 8
`define SPG_OP_WREN 8'h06
`define SPG_OP_WRSR 8'h01
`define SPG_OP_PP 8'h02
`define SPG_OP_SE 8'hD8
`define SPG_OP_SSE 8'h20
`define SPG_OP_CHE 8'h60
`define SPG_OP_RDSR 8'h05
`define SPG_CMD_NONE 3'h0
`define SPG_CMD_WRSR 3'h1
`define SPG_CMD_PROG 3'h2
`define SPG_CMD_ERASE 3'h3
`endif

// ### hw/spg_guard.v
`include "spg_defs.vh"
// Notes on behaviour
// (RULE1) pause begins when pause input falls while serial clock is low
// (RULE2) pause ends when pause input rises
// (RULE3) host keeps pause input steady while serial clock is high
// (RULE4) pause input only counts while chip select is low
// (RULE5) chip select rising clears pause and resets the command interface
// (RULE6) while paused output floats, input and clock are ignored
// (RULE7) counters and partial command are kept across a pause
// (RULE8) host waits at least 300 us after supply before selecting
// (RULE9) after reset the device is in standby, nothing in progress
// (RULE10) writes refused until power-up write delay has passed
// (RULE11) write command dropped if select rises off a byte boundary
// (RULE12) page program dropped unless data ends on a whole byte
// (RULE13) status write dropped if two or more data bytes follow
module spg_guard #(
    parameter PUW_CYCLES = `SPG_PUW_CYCLES
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    input wire i_pause_n,
    input wire [7:0] i_so_data,
    output reg o_so,
    output reg o_so_oe,
    output reg o_paused,
    output reg o_write_ready,
    output reg o_exec_valid,
    output reg [2:0] o_exec_cmd,
    output reg [7:0] o_exec_data,
    output reg [15:0] o_exec_bytes,
    output reg o_busy
);
    localparam NPIN = 4;
    // bank order: select, clock, data, pause; reset values match idle pin levels
    localparam [NPIN-1:0] PIN_IDLE = 4'h9;
    wire [NPIN-1:0] pin_raw = {i_pause_n, i_si, i_sck, i_cs_n};
    wire [NPIN-1:0] pin_sync;
    reg cs_q_reg, sck_q_reg, hold_q_reg;
    reg pause_reg;
    reg [2:0] bit_cnt_reg;
    reg [15:0] byte_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] op_reg;
    reg [7:0] tx_reg;
    reg [7:0] data0_reg;
    reg [17:0] puw_cnt_reg;

    // two flops per pin; only the second flop is read by any logic
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            reg meta_reg;
            reg stable_reg;
            always @(posedge i_clk) begin
                if (!i_reset_n) begin
                    meta_reg <= PIN_IDLE[g];
                    stable_reg <= PIN_IDLE[g];
                end else begin
                    meta_reg <= pin_raw[g];
                    stable_reg <= meta_reg;
                end
            end
            assign pin_sync[g] = stable_reg;
        end
    endgenerate

    wire cs_n = pin_sync[0];
    wire sck = pin_sync[1];
    wire si = pin_sync[2];
    wire hold_n = pin_sync[3];
    // select, clock and data share the same delay, so their edges stay in order
    wire cs_rise = cs_n & ~cs_q_reg;
    wire sck_rise = sck & ~sck_q_reg;
    wire sck_fall = ~sck & sck_q_reg;
    wire hold_fall = ~hold_n & hold_q_reg;
    wire hold_rise = hold_n & ~hold_q_reg;
    wire active = ~cs_n & ~pause_reg;
    wire [7:0] byte_in = {shift_reg[6:0], si};

    function [2:0] cmd_class;
        input [7:0] op;
        begin
            case (op)
                `SPG_OP_WRSR: cmd_class = `SPG_CMD_WRSR;
                `SPG_OP_PP: cmd_class = `SPG_CMD_PROG;
                `SPG_OP_SE, `SPG_OP_SSE, `SPG_OP_CHE, `SPG_OP_WREN: cmd_class = `SPG_CMD_ERASE;
                default: cmd_class = `SPG_CMD_NONE;
            endcase
        end
    endfunction

    wire [2:0] cls = cmd_class(op_reg);
    wire on_byte = (bit_cnt_reg == 3'h0); // [RULE11] [RULE12]
    reg exec_ok;
    always @* begin
        exec_ok = 1'b0;
        case (cls)
            `SPG_CMD_WRSR: exec_ok = on_byte && (byte_cnt_reg == 16'h0002); // [RULE13]
            `SPG_CMD_PROG: exec_ok = on_byte && (byte_cnt_reg > 16'h0004); // [RULE12]
            `SPG_CMD_ERASE: exec_ok = on_byte && (byte_cnt_reg != 16'h0000); // [RULE11]
            default: exec_ok = 1'b0;
        endcase
    end

    // previous levels for edge detection, reset to the idle pin levels
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            cs_q_reg <= 1'b1;
            sck_q_reg <= 1'b0;
            hold_q_reg <= 1'b1;
        end else begin
            cs_q_reg <= cs_n;
            sck_q_reg <= sck;
            hold_q_reg <= hold_n;
        end
    end

    // counter parks at the limit, so the ready flag never drops again
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            puw_cnt_reg <= 18'h00000;
            o_write_ready <= 1'b0;
        end else begin
            if (puw_cnt_reg != PUW_CYCLES[17:0])
                puw_cnt_reg <= puw_cnt_reg + 18'h00001;
            o_write_ready <= (puw_cnt_reg == PUW_CYCLES[17:0]); // [RULE10]
        end
    end

    // pause needs clock low to start; ending it does not look at the clock
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            pause_reg <= 1'b0; // [RULE9]
            o_paused <= 1'b0;
        end else begin
            if (cs_n) begin
                pause_reg <= 1'b0; // [RULE4] [RULE5]
            end else if (hold_fall && !sck) begin
                pause_reg <= 1'b1; // [RULE1]
            end else if (hold_rise) begin
                pause_reg <= 1'b0; // [RULE2]
            end
            o_paused <= pause_reg & ~cs_n;
        end
    end

    // counters move only on unpaused clock edges, so a pause resumes mid-byte
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 16'h0000;
            shift_reg <= 8'h00;
            op_reg <= 8'h00;
            data0_reg <= 8'h00;
            o_busy <= 1'b0;
        end else if (cs_rise) begin
            // clear the opcode too; only data0_reg is kept from this frame into the next
            bit_cnt_reg <= 3'h0; // [RULE5]
            byte_cnt_reg <= 16'h0000;
            shift_reg <= 8'h00;
            op_reg <= 8'h00;
            o_busy <= 1'b0;
        end else if (active && sck_rise) begin // [RULE6] [RULE7]
            o_busy <= 1'b1;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= byte_in;
            if (bit_cnt_reg == 3'h7) begin
                byte_cnt_reg <= byte_cnt_reg + 16'h0001;
                if (byte_cnt_reg == 16'h0000)
                    op_reg <= byte_in;
                if (byte_cnt_reg == 16'h0001)
                    data0_reg <= byte_in;
            end
        end
    end

    // one-cycle strobe; the command fields hold until the next accepted one
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_exec_valid <= 1'b0;
            o_exec_cmd <= `SPG_CMD_NONE;
            o_exec_data <= 8'h00;
            o_exec_bytes <= 16'h0000;
        end else begin
            o_exec_valid <= 1'b0;
            // the decode reads the opcode before the select edge clears it
            if (cs_rise && exec_ok && o_write_ready) begin // [RULE10] [RULE11]
                o_exec_valid <= 1'b1;
                o_exec_cmd <= cls;
                o_exec_data <= data0_reg;
                o_exec_bytes <= byte_cnt_reg;
            end
        end
    end

    // a byte is taken from i_so_data at each byte start, with no lookahead
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            tx_reg <= 8'h00;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            if (cs_n) begin
                tx_reg <= i_so_data;
            end else if (active && sck_fall) begin
                // msb must stand before the first rising edge of the byte
                if (bit_cnt_reg == 3'h0) begin
                    o_so <= i_so_data[7];
                    tx_reg <= {i_so_data[6:0], 1'b0};
                end else begin
                    o_so <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end
            // write-type commands never answer, so the pin stays released for them
            o_so_oe <= active && (cls == `SPG_CMD_NONE) && (byte_cnt_reg != 16'h0000); // [RULE6]
        end
    end
endmodule // spg_guard

// ### verification/spg_guard_properties.sv
module spg_guard_checker #(parameter int PUW_CYCLES = 25000) (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_cs_n,
    input wire i_pause_n,
    input wire o_paused,
    input wire o_so_oe,
    input wire o_write_ready,
    input wire o_exec_valid
);
    timeunit 1ns; timeprecision 1ps;
    logic [31:0] up_cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    always @(posedge i_clk) up_cnt <= i_reset_n ? up_cnt + 1 : 0;
    chk_pause_entry: assert property (!i_cs_n && $fell(i_pause_n) |-> ##[1:5] o_paused) else $error("no pause");
    chk_pause_exit: assert property ($rose(i_pause_n) |-> ##[1:5] !o_paused) else $error("stuck pause");
    chk_idle_unpaused: assert property (i_cs_n [*6] |-> !o_paused) else $error("pause unselected");
    chk_paused_float: assert property (o_paused && $past(o_paused) |-> !o_so_oe) else $error("so driven");
    chk_write_gate: assert property (o_exec_valid |-> o_write_ready) else $error("early write");
    chk_ready_holds: assert property (o_write_ready |=> o_write_ready) else $error("ready fell");
    chk_reset_standby: assert property ($rose(i_reset_n) |-> !o_paused && !o_write_ready && !o_exec_valid)
        else $error("not standby");
    chk_ready_early: assert property (o_write_ready |-> up_cnt + 2 >= PUW_CYCLES) else $error("ready early");
endmodule // spg_guard_checker
bind spg_guard spg_guard_checker #(.PUW_CYCLES(PUW_CYCLES)) i_spg_guard_checker (.i_clk, .i_reset_n, .i_cs_n,
    .i_pause_n, .o_paused, .o_so_oe, .o_write_ready, .o_exec_valid);

// ### verification/spg_host_model.sv
module spg_host_model (
    input wire i_clk,
    output logic o_cs_n = 1'b1,
    output logic o_sck = 1'b0,
    output logic o_si = 1'b0,
    output logic o_pause_n = 1'b1
);
    timeunit 1ns; timeprecision 1ps;
    // sck and si wiggle while paused, so a device that listens goes wrong
    task automatic pause(input bit by_cs);
        o_pause_n <= 1'b0;
        repeat (8) @(negedge i_clk);
        {o_sck, o_si} <= {1'b1, ~o_si};
        repeat (4) @(negedge i_clk);
        o_sck <= 1'b0;
        if (by_cs) o_cs_n <= 1'b1;
        repeat (4) @(negedge i_clk);
        o_pause_n <= 1'b1;
    endtask
    task automatic frame(input [47:0] d, input int n, input int at, input bit by_cs);
        o_cs_n <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (4) @(negedge i_clk);
            if (i == at) pause(by_cs);
            if (i == n) break;
            o_si <= d[n - 1 - i];
            repeat (4) @(negedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(negedge i_clk);
            o_sck <= 1'b0;
        end
        {o_cs_n, o_si} <= {1'b1, ~o_si};
        repeat (16) @(negedge i_clk);
    endtask
endmodule // spg_host_model

// ### verification/tb_top.sv
module tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic i_clk = 1'b0, i_reset_n = 1'b0;
    logic o_so, o_so_oe, o_paused, o_write_ready, o_exec_valid, o_busy;
    logic [2:0] o_exec_cmd;
    logic [7:0] o_exec_data;
    logic [15:0] o_exec_bytes;
    wire i_cs_n, i_sck, i_si, i_pause_n;
    int n_mismatch = 0, n_compared = 0, n_exec = 0, cycles = 0;
    bit seen_pause;
    logic [7:0] rx = 8'h00;
    always #2 i_clk = ~i_clk;
    always @(posedge i_sck) if (o_so_oe === 1'b1) rx <= {rx[6:0], o_so};
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        n_exec <= n_exec + (o_exec_valid === 1'b1);
        seen_pause <= seen_pause | (o_paused === 1'b1);
        if (cycles == 20000) tally_and_finish();
    end
    spg_guard #(.PUW_CYCLES(400)) i_spg_guard (.i_clk, .i_reset_n, .i_cs_n, .i_sck, .i_si, .i_pause_n,
        .i_so_data(8'hA5), .o_so, .o_so_oe, .o_paused, .o_write_ready, .o_exec_valid, .o_exec_cmd, .o_exec_data,
        .o_exec_bytes, .o_busy);
    spg_host_model i_spg_host_model (.i_clk, .o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si), .o_pause_n(i_pause_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("wrong value at %0t: %h %h", $time, got, exp);
    endtask
    task automatic run(input [47:0] d, input int n, input int at, input bit ok, input [2:0] c, input [4:0] b);
        int k;
        k = n_exec;
        seen_pause = 0;
        i_spg_host_model.frame(d, n, at, 0);
        chk(n_exec - k, ok);
        if (ok) chk({o_exec_cmd, o_exec_bytes[4:0], b > 1 ? o_exec_data : 8'h0}, {c, b, b > 1 ? d[n - 9 -: 8] : 8'h0});
    endtask
    task automatic t_words();
        run(16'h015A, 16, 99, 1, 1, 2);
        run(24'h015A33, 24, 99, 0, 0, 0);
        run(15'h00AD, 15, 99, 0, 0, 0);
        run(40'h02A50100C3, 40, 99, 1, 2, 5);
        run(44'h02A50100C3F, 44, 99, 0, 0, 0);
        run(8'h06, 8, 99, 1, 3, 1);
    endtask
    task automatic t_pause();
        run(16'h0196, 16, 5, 1, 1, 2);
        chk(seen_pause, 1);
        seen_pause = 0;
        i_spg_host_model.pause(0);
        chk(seen_pause, 0);
        i_spg_host_model.frame(12'h015, 12, 12, 1);
        chk({seen_pause, o_paused}, 2'b10);
        run(16'h01C3, 16, 99, 1, 1, 2);
    endtask
    task automatic t_read();
        run(16'h0500, 16, 12, 0, 0, 0);
        chk({seen_pause, o_so_oe, rx}, {2'b10, 8'hA5});
    endtask
    task automatic tally_and_finish();
        n_mismatch += (cycles >= 20000);
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        chk({o_paused, o_write_ready, o_exec_valid, o_busy}, 0);
        repeat (10) @(negedge i_clk);
        run(8'h06, 8, 99, 0, 0, 0);
        for (int k = 0; k < 999 && o_write_ready !== 1'b1; k++) @(negedge i_clk);
        chk(o_write_ready, 1);
        t_words();
        t_pause();
        t_read();
        tally_and_finish();
    end
endmodule // tb_top
